// ==== tb/stream_protocol_checker_tb.sv ====
`timescale 1ns/1ns
module stream_protocol_checker_tb;
    logic        clock = 1'h0;
    logic        rst_n = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, error_any;
    logic        st_valid, st_ready, st_sop, st_eop;
    logic [1:0]  bresp, rresp, st_channel, st_empty;
    logic [0:0]  st_error;
    logic [31:0] rdata;
    logic [6:0]  error_flags;
    int          errors = 0;
    int          cmp_count = 0;
    logic [8:0]  tr [7] = '{9'h1c8, 9'h18c, 9'h1a8, 9'h1e8, 9'h000, 9'h1e0, 9'h080};
    int          ci [7] = '{1, 3, 9, 11, 12, 13, 15};
    logic [31:0] ce [7] = '{32'h5, 32'h3, 32'h1, 32'h2, 32'h1, 32'h1, 32'h2};
    stream_protocol_checker #(.SYMBOLS(3), .CHANNEL_W(2), .EMPTY_W(2), .MAX_CHANNEL(2)) uut (
        .clock(clock), .rst_n(rst_n), .st_valid(st_valid), .st_ready(st_ready),
        .st_sop(st_sop), .st_eop(st_eop), .st_channel(st_channel), .st_error(st_error),
        .st_empty(st_empty), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .error_flags(error_flags), .error_any(error_any));
    stream_source_model src (.clock(clock), .st_valid(st_valid), .st_ready(st_ready),
        .st_sop(st_sop), .st_eop(st_eop), .st_channel(st_channel), .st_error(st_error),
        .st_empty(st_empty));
    always #5 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, r});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        chk(rdata, d);
        chk({30'h0, rresp}, {30'h0, r});
    endtask
    // Flags land one edge after the beat; cleared again so each case stands alone
    task automatic viol(input logic [8:0] b, input logic [6:0] f);
        src.beat(b);
        src.beat(9'h080);
        #1;
        chk({25'h0, error_flags}, {25'h0, f});
        rd(stream_chk_pkg::OFF_ERRORS, {25'h0, f}, stream_chk_pkg::RESP_OKAY);
        wr(stream_chk_pkg::OFF_ERRORS, 32'h7f, stream_chk_pkg::RESP_OKAY);
    endtask
    task automatic complete_run();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        rd(stream_chk_pkg::OFF_CHECK_EN, 32'h7f, stream_chk_pkg::RESP_OKAY);
        rd(stream_chk_pkg::OFF_COVER_EN, 32'h7fff, stream_chk_pkg::RESP_OKAY);
        rd(stream_chk_pkg::OFF_CONFIG, 32'h7e, stream_chk_pkg::RESP_OKAY);
        foreach (tr[i]) src.beat(tr[i]);
        foreach (ci[i]) rd(stream_chk_pkg::OFF_COUNT + 12'(4 * ci[i]), ce[i],
            stream_chk_pkg::RESP_OKAY);
        rd(stream_chk_pkg::OFF_HOLES, 32'h124, stream_chk_pkg::RESP_OKAY);
        rd(stream_chk_pkg::OFF_ERRORS, 32'h0, stream_chk_pkg::RESP_OKAY);
        rd(12'h020, 32'h0, stream_chk_pkg::RESP_SLVERR);
        wr(stream_chk_pkg::OFF_CONFIG, 32'h0, stream_chk_pkg::RESP_SLVERR);
        wstrb <= 4'he;
        wr(stream_chk_pkg::OFF_COVER_EN, 32'h0, stream_chk_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rd(stream_chk_pkg::OFF_COVER_EN, 32'hff, stream_chk_pkg::RESP_OKAY);
        rd(stream_chk_pkg::OFF_HOLES, 32'h24, stream_chk_pkg::RESP_OKAY);
        viol(9'h180, 7'h08);
        viol(9'h1a0, 7'h18);
        viol(9'h1c0, 7'h00);
        viol(9'h1c0, 7'h20);
        viol(9'h1b8, 7'h04);
        viol(9'h1e3, 7'h02);
        viol(9'h1c1, 7'h01);
        viol(9'h1a0, 7'h00);
        wr(stream_chk_pkg::OFF_CHECK_EN, 32'h7e, stream_chk_pkg::RESP_OKAY);
        viol(9'h1c1, 7'h00);
        viol(9'h1a0, 7'h00);
        rst_n <= 1'h0;
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        rd(stream_chk_pkg::OFF_CHECK_EN, 32'h7f, stream_chk_pkg::RESP_OKAY);
        rd(stream_chk_pkg::OFF_COVER_EN, 32'h7fff, stream_chk_pkg::RESP_OKAY);
        rd(stream_chk_pkg::OFF_COUNT + 12'h004, 32'h0, stream_chk_pkg::RESP_OKAY);
        complete_run();
    end
    // Run needs well under 2000 cycles; this margin only catches a hang
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule

// ==== tb/stream_rules_checker.sv ====
`timescale 1ns/1ns
module stream_rules_checker #(
    parameter int SYMBOLS     = 4,
    parameter int MAX_CHANNEL = 1,
    parameter int CHANNEL_W   = 1,
    parameter int EMPTY_W     = 1
) (
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic                 st_valid,
    input wire logic                 st_ready,
    input wire logic                 st_sop,
    input wire logic                 st_eop,
    input wire logic [CHANNEL_W-1:0] st_channel,
    input wire logic [EMPTY_W-1:0]   st_empty,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic [6:0]           error_flags,
    input wire logic                 error_any
);
    logic in_pkt_q;
    logic in_pkt_d;
    logic eop_seen_q;
    logic beat;
    assign beat = st_valid && st_ready;
    always_comb begin
        in_pkt_d = in_pkt_q;
        if (beat && st_sop) in_pkt_d = !st_eop;
        else if (beat && st_eop) in_pkt_d = 1'h0;
        if (!rst_n) in_pkt_d = 1'h0;
    end
    always_ff @(posedge clock) in_pkt_q <= in_pkt_d;
    always_ff @(posedge clock)
        eop_seen_q <= rst_n && (beat && st_eop || eop_seen_q && !(beat && st_sop));
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ch_range_a: assert property (st_valid && st_channel >= MAX_CHANNEL |=> error_flags[2])
        else $error("channel flag missing");
    empty_range_a: assert property (st_valid && st_empty >= SYMBOLS |=> error_flags[1])
        else $error("empty range flag missing");
    outside_pkt_a: assert property (beat && !st_sop && !in_pkt_q |=> error_flags[3])
        else $error("outside beat flag missing");
    no_start_a: assert property (beat && st_eop && !st_sop && eop_seen_q
        |=> error_flags[4])
        else $error("missing start flag");
    no_end_a: assert property (beat && st_sop && in_pkt_q |=> error_flags[5])
        else $error("missing end flag");
    any_flag_a: assert property (error_any == |error_flags)
        else $error("summary flag wrong");
    flag_hold_a: assert property (|($past(error_flags) & ~error_flags) |-> $rose(s_axi_bvalid))
        else $error("flag dropped without write");
    read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during answer");
endmodule
bind stream_protocol_checker stream_rules_checker #(.SYMBOLS(SYMBOLS),
    .MAX_CHANNEL(MAX_CHANNEL), .CHANNEL_W(CHANNEL_W), .EMPTY_W(EMPTY_W)
) chk (.clock(clock), .rst_n(rst_n), .st_valid(st_valid), .st_ready(st_ready),
    .st_sop(st_sop), .st_eop(st_eop), .st_channel(st_channel), .st_empty(st_empty),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .error_flags(error_flags), .error_any(error_any));

// ==== tb/stream_source_model.sv ====
`timescale 1ns/1ns
module stream_source_model (
    input  wire logic  clock,
    output logic       st_valid,
    output logic       st_ready,
    output logic       st_sop,
    output logic       st_eop,
    output logic [1:0] st_channel,
    output logic [0:0] st_error,
    output logic [1:0] st_empty
);
    logic [8:0] bus_q = 9'h080;
    assign {st_valid, st_ready, st_sop, st_eop, st_channel, st_error, st_empty} = bus_q;
    // Idle payload flips so stale fields never look like a held beat
    task automatic beat(input logic [8:0] b);
        @(posedge clock);
        bus_q <= b[8] ? b : {b[8:5], ~bus_q[4:0]};
    endtask
endmodule

// ==== verilog/stream_chk_pkg.sv ====
// Operation
// - Flag nonzero empty count on any valid beat that is not packet end.
// - Flag empty count equal to or above symbols per beat.
// - Flag valid beat whose channel is at or above the channel limit.
// - With packets, flag valid beats between a packet end and next start.
// - Flag two packet ends with no packet start between them.
// - Flag a packet start not closed by an end before the next start.
// - With nonzero delay, flag valid high that many cycles after ready fell.
// - Each check has its own enable; all enables come up on.
// - A check is forced off when its signals are not configured.
// - A failing enabled check raises an error flag naming that check.
// - One build-time option turns off all protocol checking.
// - Each coverage point has an enable; disabled points report no hole.
// - Coverage enables come up on; packet points forced off without packets.
// - Count idle cycles and valid beats separately.
// - Count back-to-back beats on same and different channels, needs channel.
// - Count back-to-back packets by channel, transaction and single cycle.
// - Count packets whose channel changes between first and last beat.
// - Cover each error bit and error mid-packet; needs error signal.
// - Count packets preceded by idle cycles since the previous packet.
// - Count cycles carrying more than one packet boundary; needs packets.
// - Count cycles with ready and valid both low; needs ready.
// - Count completed packets per channel value; needs packets.
// - Widths and counts are parameters; each signal group is optional.
package stream_chk_pkg;
    localparam int NUM_CHECKS       = 7;
    localparam int CK_EMPTY_NONLAST = 0;
    localparam int CK_EMPTY_RANGE   = 1;
    localparam int CK_CHANNEL_MAX   = 2;
    localparam int CK_OUTSIDE_PKT   = 3;
    localparam int CK_MISSING_START = 4;
    localparam int CK_MISSING_END   = 5;
    localparam int CK_VALID_LATE    = 6;

    localparam int NUM_FIXED        = 13;
    localparam int CV_ALL_IDLE      = 0;
    localparam int CV_ALL_VALID     = 1;
    localparam int CV_B2B_DIFF_CH   = 2;
    localparam int CV_B2B_SAME_CH   = 3;
    localparam int CV_PKT_SAME_CH   = 4;
    localparam int CV_PKT_DIFF_CH   = 5;
    localparam int CV_PKT_DIFF_TR   = 6;
    localparam int CV_PKT_ONE_CYC   = 7;
    localparam int CV_CH_CHANGE     = 8;
    localparam int CV_ERR_MID_PKT   = 9;
    localparam int CV_IDLE_BETWEEN  = 10;
    localparam int CV_MULTI_PKT     = 11;
    localparam int CV_NONE_NONE     = 12;
    localparam int CV_ERR_BITS      = 13;
    localparam int CV_PKT_CHAN      = 14;
    localparam int NUM_COVER        = 15;

    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CHECK_EN = 12'h000;
    localparam logic [11:0] OFF_COVER_EN = 12'h004;
    localparam logic [11:0] OFF_ERRORS   = 12'h008;
    localparam logic [11:0] OFF_CONFIG   = 12'h00c;
    localparam logic [11:0] OFF_HOLES    = 12'h010;
    localparam logic [11:0] OFF_COUNT    = 12'h100;

    localparam logic [31:0] CHECK_EN_RST = 32'h0000007f;
    localparam logic [31:0] COVER_EN_RST = 32'h00007fff;
    localparam logic [31:0] ERRORS_RST   = 32'h00000000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/stream_protocol_checker.sv ====
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module stream_protocol_checker #(
    parameter int SYMBOL_W             = 8,
    parameter int SYMBOLS              = 4,
    parameter int CHANNEL_W            = 1,
    parameter int ERROR_W              = 1,
    parameter int EMPTY_W              = 1,
    parameter bit USE_PACKET           = 1'b1,
    parameter bit USE_CHANNEL          = 1'b1,
    parameter bit USE_ERROR            = 1'b1,
    parameter bit USE_VALID            = 1'b1,
    parameter bit USE_EMPTY            = 1'b1,
    parameter bit USE_READY            = 1'b1,
    parameter int READY_TO_VALID_DELAY = 0,
    parameter int MAX_CHANNEL          = 1,
    parameter int CNT_W                = 32,
    parameter bit GLOBAL_CHECK_OFF     = 1'b0
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 st_valid,
    input  wire logic                 st_ready,
    input  wire logic                 st_sop,
    input  wire logic                 st_eop,
    input  wire logic [CHANNEL_W-1:0] st_channel,
    input  wire logic [ERROR_W-1:0]   st_error,
    input  wire logic [EMPTY_W-1:0]   st_empty,
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [6:0]                error_flags,
    output logic                      error_any
);
    localparam int NCNT  = stream_chk_pkg::NUM_FIXED + ERROR_W + MAX_CHANNEL;
    localparam int ERR0  = stream_chk_pkg::NUM_FIXED;
    localparam int CHN0  = stream_chk_pkg::NUM_FIXED + ERROR_W;
    localparam int DLY_N = (READY_TO_VALID_DELAY > 0) ? READY_TO_VALID_DELAY : 1;
    localparam int NCK   = stream_chk_pkg::NUM_CHECKS;
    localparam int NCV   = stream_chk_pkg::NUM_COVER;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // Optional groups read as inactive when absent; valid and ready read as high
    logic                 vld;
    logic                 rdy;
    logic                 beat;
    logic                 sop;
    logic                 eop;
    logic [CHANNEL_W-1:0] ch;
    logic [ERROR_W-1:0]   err;
    logic [EMPTY_W-1:0]   emp;

    always_comb begin
        vld  = USE_VALID ? st_valid : 1'b1;
        rdy  = USE_READY ? st_ready : 1'b1;
        // With a nonzero delay a valid beat is always accepted
        beat = vld & (rdy | (READY_TO_VALID_DELAY > 0));
        sop  = USE_PACKET & st_sop;
        eop  = USE_PACKET & st_eop;
        ch   = USE_CHANNEL ? st_channel : '0;
        err  = USE_ERROR ? st_error : '0;
        emp  = USE_EMPTY ? st_empty : '0;
    end

    // Check and coverage availability from configuration
    logic [NCK-1:0] chk_avail;
    logic [NCV-1:0] cov_avail;
    logic [NCK-1:0] chk_en_q, chk_en_d;
    logic [NCV-1:0] cov_en_q, cov_en_d;
    logic [NCK-1:0] chk_on;
    logic [NCV-1:0] cov_on;

    always_comb begin
        chk_avail = '0;
        chk_avail[stream_chk_pkg::CK_EMPTY_NONLAST] = USE_PACKET & USE_EMPTY;
        chk_avail[stream_chk_pkg::CK_EMPTY_RANGE]   = USE_EMPTY;
        chk_avail[stream_chk_pkg::CK_CHANNEL_MAX]   = USE_CHANNEL;
        chk_avail[stream_chk_pkg::CK_OUTSIDE_PKT]   = USE_PACKET;
        chk_avail[stream_chk_pkg::CK_MISSING_START] = USE_PACKET;
        chk_avail[stream_chk_pkg::CK_MISSING_END]   = USE_PACKET;
        chk_avail[stream_chk_pkg::CK_VALID_LATE]    = USE_READY & USE_VALID
                                                     & (READY_TO_VALID_DELAY > 0);
        cov_avail = '1;
        cov_avail[stream_chk_pkg::CV_B2B_DIFF_CH]  = USE_CHANNEL;
        cov_avail[stream_chk_pkg::CV_B2B_SAME_CH]  = USE_CHANNEL;
        cov_avail[stream_chk_pkg::CV_PKT_SAME_CH]  = USE_PACKET & USE_CHANNEL;
        cov_avail[stream_chk_pkg::CV_PKT_DIFF_CH]  = USE_PACKET & USE_CHANNEL;
        cov_avail[stream_chk_pkg::CV_PKT_DIFF_TR]  = USE_PACKET & USE_CHANNEL;
        cov_avail[stream_chk_pkg::CV_PKT_ONE_CYC]  = USE_PACKET & USE_CHANNEL;
        cov_avail[stream_chk_pkg::CV_CH_CHANGE]    = USE_PACKET & USE_CHANNEL;
        cov_avail[stream_chk_pkg::CV_ERR_MID_PKT]  = USE_ERROR & USE_PACKET;
        cov_avail[stream_chk_pkg::CV_IDLE_BETWEEN] = USE_PACKET;
        cov_avail[stream_chk_pkg::CV_MULTI_PKT]    = USE_PACKET;
        cov_avail[stream_chk_pkg::CV_NONE_NONE]    = USE_READY;
        cov_avail[stream_chk_pkg::CV_ERR_BITS]     = USE_ERROR;
        cov_avail[stream_chk_pkg::CV_PKT_CHAN]     = USE_PACKET;
        chk_on = chk_en_q & chk_avail & {NCK{~GLOBAL_CHECK_OFF}};
        cov_on = cov_en_q & cov_avail;
    end

    // Packet and history state
    logic             in_pkt_q, in_pkt_d;
    logic             last_eop_q, last_eop_d;
    logic             prev_beat_q, prev_beat_d;
    logic             prev_eop_q, prev_eop_d;
    logic             idle_seen_q, idle_seen_d;
    logic             ch_chg_q, ch_chg_d;
    logic             rdy_prev_q, rdy_prev_d;
    logic [CHANNEL_W-1:0] prev_ch_q, prev_ch_d;
    logic [CHANNEL_W-1:0] pkt_ch_q, pkt_ch_d;
    logic [DLY_N-1:0] fell_q, fell_d;
    logic [NCK-1:0]   viol;

    always_comb begin
        viol = '0;
        viol[stream_chk_pkg::CK_EMPTY_NONLAST] = vld & (emp != '0) & ~eop;
        viol[stream_chk_pkg::CK_EMPTY_RANGE]   = vld & (32'(emp) >= SYMBOLS);
        viol[stream_chk_pkg::CK_CHANNEL_MAX]   = vld & (32'(ch) >= MAX_CHANNEL);
        viol[stream_chk_pkg::CK_OUTSIDE_PKT]   = beat & ~in_pkt_q & ~sop;
        viol[stream_chk_pkg::CK_MISSING_START] = beat & eop & ~sop & last_eop_q;
        viol[stream_chk_pkg::CK_MISSING_END]   = beat & sop & in_pkt_q;
        viol[stream_chk_pkg::CK_VALID_LATE]    = vld & fell_q[DLY_N-1];

        in_pkt_d    = in_pkt_q;
        last_eop_d  = last_eop_q;
        pkt_ch_d    = pkt_ch_q;
        ch_chg_d    = ch_chg_q;
        idle_seen_d = idle_seen_q;
        if (beat) begin
            in_pkt_d = (in_pkt_q | sop) & ~eop;
            if (sop) begin
                pkt_ch_d   = ch;
                ch_chg_d   = 1'b0;
                last_eop_d = 1'b0;
            end else if (in_pkt_q && ch != pkt_ch_q) begin
                ch_chg_d = 1'b1;
            end
            if (eop) begin
                last_eop_d  = 1'b1;
                idle_seen_d = 1'b0;
            end
        end else if (!vld) begin
            idle_seen_d = 1'b1;
        end
        prev_beat_d = beat;
        prev_eop_d  = beat & eop;
        prev_ch_d   = beat ? ch : prev_ch_q;
        rdy_prev_d  = rdy;
        // Bit k set means ready fell k+1 cycles ago
        fell_d      = (fell_q << 1) | DLY_N'(rdy_prev_q & ~rdy);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_pkt_q    <= 1'b0;
            last_eop_q  <= 1'b0;
            prev_beat_q <= 1'b0;
            prev_eop_q  <= 1'b0;
            idle_seen_q <= 1'b0;
            ch_chg_q    <= 1'b0;
            rdy_prev_q  <= 1'b0;
            prev_ch_q   <= '0;
            pkt_ch_q    <= '0;
            fell_q      <= '0;
        end else begin
            in_pkt_q    <= in_pkt_d;
            last_eop_q  <= last_eop_d;
            prev_beat_q <= prev_beat_d;
            prev_eop_q  <= prev_eop_d;
            idle_seen_q <= idle_seen_d;
            ch_chg_q    <= ch_chg_d;
            rdy_prev_q  <= rdy_prev_d;
            prev_ch_q   <= prev_ch_d;
            pkt_ch_q    <= pkt_ch_d;
            fell_q      <= fell_d;
        end
    end

    // Coverage counters
    logic [NCNT-1:0]  inc;
    logic [CNT_W-1:0] cnt_q [NCNT];
    logic [CNT_W-1:0] cnt_d [NCNT];
    logic             b2b_pkt;
    logic [NCV-1:0]   holes;

    always_comb begin
        b2b_pkt = beat & sop & prev_beat_q & prev_eop_q;
        inc = '0;
        inc[stream_chk_pkg::CV_ALL_IDLE]     = ~vld;
        inc[stream_chk_pkg::CV_ALL_VALID]    = beat;
        inc[stream_chk_pkg::CV_B2B_DIFF_CH]  = beat & prev_beat_q & (ch != prev_ch_q);
        inc[stream_chk_pkg::CV_B2B_SAME_CH]  = beat & prev_beat_q & (ch == prev_ch_q);
        inc[stream_chk_pkg::CV_PKT_SAME_CH]  = b2b_pkt & (ch == prev_ch_q);
        inc[stream_chk_pkg::CV_PKT_DIFF_CH]  = b2b_pkt & (ch != prev_ch_q);
        inc[stream_chk_pkg::CV_PKT_DIFF_TR]  = beat & sop & last_eop_q & ~prev_beat_q;
        inc[stream_chk_pkg::CV_PKT_ONE_CYC]  = b2b_pkt & eop;
        inc[stream_chk_pkg::CV_CH_CHANGE]    = beat & eop & in_pkt_q
                                              & (ch_chg_q | (ch != pkt_ch_q));
        inc[stream_chk_pkg::CV_ERR_MID_PKT]  = beat & (err != '0) & in_pkt_q & ~eop;
        inc[stream_chk_pkg::CV_IDLE_BETWEEN] = beat & sop & last_eop_q & idle_seen_q;
        inc[stream_chk_pkg::CV_MULTI_PKT]    = beat & sop & eop;
        inc[stream_chk_pkg::CV_NONE_NONE]    = ~vld & ~rdy;
        for (int i = 0; i < ERROR_W; i++) begin
            inc[ERR0+i] = beat & err[i] & cov_on[stream_chk_pkg::CV_ERR_BITS];
        end
        for (int c = 0; c < MAX_CHANNEL; c++) begin
            inc[CHN0+c] = beat & eop & (32'(ch) == c)
                          & cov_on[stream_chk_pkg::CV_PKT_CHAN];
        end
        inc[stream_chk_pkg::NUM_FIXED-1:0] = inc[stream_chk_pkg::NUM_FIXED-1:0]
                                           & cov_on[stream_chk_pkg::NUM_FIXED-1:0];
        holes = '0;
        for (int i = 0; i < NCNT; i++) begin
            // Saturate so a long run never reads back as a hole
            cnt_d[i] = (inc[i] && cnt_q[i] != CNT_MAX) ? cnt_q[i] + 1'b1 : cnt_q[i];
            if (cnt_q[i] == '0) begin
                if (i < ERR0) begin
                    holes[i] = 1'b1;
                end else if (i < CHN0) begin
                    holes[stream_chk_pkg::CV_ERR_BITS] = 1'b1;
                end else begin
                    holes[stream_chk_pkg::CV_PKT_CHAN] = 1'b1;
                end
            end
        end
        holes = holes & cov_on;
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < NCNT; i++) begin
            if (!rst_n) begin
                cnt_q[i] <= '0;
            end else begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    // Register bus
    logic        aw_hold_q, aw_hold_d;
    logic        w_hold_q, w_hold_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NCK-1:0] err_q, err_d;
    logic        do_wr;
    logic [11:0] wa;
    logic [31:0] wd;
    logic [31:0] bmask;
    logic [31:0] rv;
    logic        rhit;
    logic        whit;
    int          ridx;

    always_comb begin
        s_axi_awready = ~aw_hold_q & ~bvalid_q;
        s_axi_wready  = ~w_hold_q & ~bvalid_q;
        s_axi_arready = ~rvalid_q;
        aw_hold_d = aw_hold_q | (s_axi_awvalid & s_axi_awready);
        w_hold_d  = w_hold_q | (s_axi_wvalid & s_axi_wready);
        aw_addr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : aw_addr_q;
        w_data_d  = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data_q;
        w_strb_d  = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : w_strb_q;
        do_wr = aw_hold_d & w_hold_d & ~bvalid_q;
        wa    = aw_addr_d;
        wd    = w_data_d;
        bmask = {{8{w_strb_d[3]}}, {8{w_strb_d[2]}}, {8{w_strb_d[1]}}, {8{w_strb_d[0]}}};
        whit  = (wa == stream_chk_pkg::OFF_CHECK_EN) || (wa == stream_chk_pkg::OFF_COVER_EN)
                || (wa == stream_chk_pkg::OFF_ERRORS);
        bvalid_d = bvalid_q & ~s_axi_bready;
        bresp_d  = bresp_q;
        chk_en_d = chk_en_q;
        cov_en_d = cov_en_q;
        err_d    = err_q | (viol & chk_on);
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = whit ? stream_chk_pkg::RESP_OKAY : stream_chk_pkg::RESP_SLVERR;
            if (wa == stream_chk_pkg::OFF_CHECK_EN) begin
                chk_en_d = NCK'((chk_en_q & ~bmask) | (wd & bmask));
            end
            if (wa == stream_chk_pkg::OFF_COVER_EN) begin
                cov_en_d = NCV'((cov_en_q & ~bmask) | (wd & bmask));
            end
            if (wa == stream_chk_pkg::OFF_ERRORS) begin
                // Write one clears; a new failure in the same cycle stays set
                err_d = (err_q & ~NCK'(wd & bmask)) | (viol & chk_on);
            end
        end

        ridx = int'((s_axi_araddr - stream_chk_pkg::OFF_COUNT) >> 2);
        rhit = 1'b1;
        rv   = '0;
        if (s_axi_araddr == stream_chk_pkg::OFF_CHECK_EN) begin
            rv = 32'(chk_en_q);
        end else if (s_axi_araddr == stream_chk_pkg::OFF_COVER_EN) begin
            rv = 32'(cov_en_q);
        end else if (s_axi_araddr == stream_chk_pkg::OFF_ERRORS) begin
            rv = 32'(err_q);
        end else if (s_axi_araddr == stream_chk_pkg::OFF_CONFIG) begin
            rv = 32'({USE_READY, USE_EMPTY, USE_VALID, USE_ERROR,
                      USE_CHANNEL, USE_PACKET, GLOBAL_CHECK_OFF});
        end else if (s_axi_araddr == stream_chk_pkg::OFF_HOLES) begin
            rv = 32'(holes);
        end else if (s_axi_araddr >= stream_chk_pkg::OFF_COUNT && s_axi_araddr[1:0] == 2'h0
                     && ridx < NCNT) begin
            rv = 32'(cnt_q[ridx]);
        end else begin
            rhit = 1'b0;
        end
        rvalid_d = rvalid_q & ~s_axi_rready;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rdata_d  = rv;
            rresp_d  = rhit ? stream_chk_pkg::RESP_OKAY : stream_chk_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= stream_chk_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= stream_chk_pkg::RESP_OKAY;
            rdata_q   <= '0;
            chk_en_q  <= NCK'(stream_chk_pkg::CHECK_EN_RST);
            cov_en_q  <= NCV'(stream_chk_pkg::COVER_EN_RST);
            err_q     <= NCK'(stream_chk_pkg::ERRORS_RST);
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            chk_en_q  <= chk_en_d;
            cov_en_q  <= cov_en_d;
            err_q     <= err_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;
    assign error_flags  = err_q;
    assign error_any    = |err_q;
endmodule
